// >>> core/ldr_config_regs.sv
// axi4-lite register bank for lead-off and per-channel configuration
// assumes one master, one clock, synchronous active-low reset
`default_nettype none

module ldr_config_regs #(
    parameter int NUM_CHANNELS = 8,
    parameter int ADDR_W = 8
) (
    // clock and reset
    input wire logic aclk,
    input wire logic aresetn,
    // write address channel
    input wire logic [ADDR_W-1:0] s_axi_awaddr,
    input wire logic [2:0] s_axi_awprot,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    // write data channel
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    // write response channel
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    // read address channel
    input wire logic [ADDR_W-1:0] s_axi_araddr,
    input wire logic [2:0] s_axi_arprot,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    // read data channel
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    // lead-off analog controls
    output var logic [9:0] threshold_high_permille,
    output var logic [9:0] threshold_low_permille,
    output var logic [14:0] excitation_current_na,
    output var logic ac_detect_enable,
    output var logic dc_detect_enable,
    output var logic [7:0] lead_off_positive_sense,
    // channel controls
    output var ldr_pkg::ldr_chan_t [7:0] channel_settings,
    output var logic [7:0][4:0] amplifier_gain_value,
    // bias controls
    output var logic [7:0] bias_positive_route,
    output var logic bias_measure_enable,
    output var logic [7:0] bias_measure_route
);
    import ldr_pkg::*;

    localparam int IDX_W = ADDR_W - 2;
    // bits that the fitted variant implements
    localparam logic [7:0] IMPL_MASK = 8'((9'h1 << NUM_CHANNELS) - 9'h1);

    ////////////////////////////////////////////////////////////////////////////////
    // register state
    ldr_lead_off_t lead_off_reg; // lead-off control
    ldr_chan_t [7:0] chan_reg; // per-channel settings
    logic [7:0] bias_pos_reg; // bias positive select
    logic [7:0] sense_pos_reg; // positive lead-off sense
    logic bias_measure_reg; // bias measure enable
    logic [7:0] status_byte; // read-only status

    // write path state
    logic aw_held_reg; // address waiting
    logic [IDX_W-1:0] aw_idx_reg; // latched word index
    logic w_held_reg; // data waiting
    logic [7:0] w_data_reg; // latched low byte
    logic w_strb_reg; // low-lane enable
    logic bvalid_reg;
    logic [1:0] bresp_reg;
    logic do_write; // both halves present, response free
    logic wr_en; // byte actually written

    // read path state
    logic rvalid_reg;
    logic [31:0] rdata_reg;
    logic [1:0] rresp_reg;
    logic [7:0] rd_byte;
    logic [IDX_W-1:0] ar_idx;

    ////////////////////////////////////////////////////////////////////////////////
    // address decode, shared by read and write
    function automatic logic idx_mapped(input logic [IDX_W-1:0] idx);
        return (idx == IDX_W'(IDX_LEAD_OFF)) || (idx == IDX_W'(IDX_BIAS_POS)) ||
            (idx == IDX_W'(IDX_SENSE_POS)) || (idx == IDX_W'(IDX_BIAS_CTRL)) ||
            (idx == IDX_W'(IDX_STATUS)) ||
            ((idx >= IDX_W'(IDX_CHAN_FIRST)) && (idx <= IDX_W'(IDX_CHAN_LAST)));
    endfunction

    ////////////////////////////////////////////////////////////////////////////////
    // axi write channels
    assign s_axi_awready = !aw_held_reg;
    assign s_axi_wready = !w_held_reg;
    assign s_axi_bvalid = bvalid_reg;
    assign s_axi_bresp = bresp_reg;
    assign do_write = aw_held_reg && w_held_reg && !bvalid_reg;
    assign wr_en = do_write && w_strb_reg;

    // latch the write address
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            aw_held_reg <= 1'b0;
            aw_idx_reg <= '0;
        end else if (s_axi_awvalid && !aw_held_reg) begin
            aw_held_reg <= 1'b1;
            aw_idx_reg <= s_axi_awaddr[ADDR_W-1:2];
        end else if (do_write) begin
            aw_held_reg <= 1'b0;
        end
    end

    // latch the write data, only the low lane matters
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            w_held_reg <= 1'b0;
            w_data_reg <= 8'h00;
            w_strb_reg <= 1'b0;
        end else if (s_axi_wvalid && !w_held_reg) begin
            w_held_reg <= 1'b1;
            w_data_reg <= s_axi_wdata[7:0];
            w_strb_reg <= s_axi_wstrb[0];
        end else if (do_write) begin
            w_held_reg <= 1'b0;
        end
    end

    // write response, error for unmapped or read-only words
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            bvalid_reg <= 1'b0;
            bresp_reg <= RESP_OKAY;
        end else if (do_write) begin
            bvalid_reg <= 1'b1;
            bresp_reg <= (idx_mapped(aw_idx_reg) && aw_idx_reg != IDX_W'(IDX_STATUS)) ?
                RESP_OKAY : RESP_SLVERR;
        end else if (s_axi_bready) begin
            bvalid_reg <= 1'b0;
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // lead-off control register
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            lead_off_reg <= ldr_lead_off_t'(RST_LEAD_OFF); // [RQ1] [RQ19]
        end else if (wr_en && aw_idx_reg == IDX_W'(IDX_LEAD_OFF)) begin
            lead_off_reg <= ldr_lead_off_t'(w_data_reg); // [RQ19]
        end
    end

    // channel settings, one register per channel
    genvar gi;
    generate
        for (gi = 0; gi < 8; gi++) begin : g_chan
            always_ff @(posedge aclk) begin
                if (!aresetn) begin
                    chan_reg[gi] <= ldr_chan_t'(RST_CHAN); // [RQ8]
                end else if (wr_en && aw_idx_reg == IDX_W'(IDX_CHAN_FIRST + 6'(gi))) begin
                    chan_reg[gi] <= ldr_chan_t'(w_data_reg); // [RQ8] [RQ19]
                end
            end
        end
    endgenerate

    // per-channel select registers; absent channel bits never store
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            bias_pos_reg <= RST_BIAS_POS; // [RQ14]
            sense_pos_reg <= RST_SENSE_POS; // [RQ18]
        end else if (wr_en && aw_idx_reg == IDX_W'(IDX_BIAS_POS)) begin
            bias_pos_reg <= w_data_reg & IMPL_MASK; // [RQ14] [RQ15]
        end else if (wr_en && aw_idx_reg == IDX_W'(IDX_SENSE_POS)) begin
            sense_pos_reg <= w_data_reg & IMPL_MASK; // [RQ18]
        end
    end

    // bias measure enable, bit zero of the bias control word
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            bias_measure_reg <= RST_BIAS_CTRL[0];
        end else if (wr_en && aw_idx_reg == IDX_W'(IDX_BIAS_CTRL)) begin
            bias_measure_reg <= w_data_reg[0]; // [RQ17]
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // status: configurations software should not leave in place
    always_comb begin
        status_byte = 8'h00;
        // sense enabled while detection is off
        status_byte[0] = (|sense_pos_reg) && lead_off_reg.detection_mode == MODE_OFF;
        // unusable detection mode
        status_byte[1] = lead_off_reg.detection_mode == MODE_RSVD;
        for (int i = 0; i < 8; i++) begin
            // unusable gain code
            status_byte[2] = status_byte[2] || chan_reg[i].amplifier_gain == GAIN_RSVD;
            // powered down but input not shorted
            status_byte[3] = status_byte[3] || (chan_reg[i].channel_powerdown &&
                chan_reg[i].input_selector != SEL_SHORTED);
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // read path
    assign ar_idx = s_axi_araddr[ADDR_W-1:2];
    assign s_axi_arready = !rvalid_reg;
    assign s_axi_rvalid = rvalid_reg;
    assign s_axi_rdata = rdata_reg;
    assign s_axi_rresp = rresp_reg;

    // read multiplexer
    always_comb begin
        rd_byte = 8'h00;
        if (ar_idx == IDX_W'(IDX_LEAD_OFF)) begin
            rd_byte = lead_off_reg; // [RQ19]
        end else if (ar_idx >= IDX_W'(IDX_CHAN_FIRST) && ar_idx <= IDX_W'(IDX_CHAN_LAST)) begin
            rd_byte = chan_reg[3'(ar_idx - IDX_W'(IDX_CHAN_FIRST))];
        end else if (ar_idx == IDX_W'(IDX_BIAS_POS)) begin
            rd_byte = bias_pos_reg;
        end else if (ar_idx == IDX_W'(IDX_SENSE_POS)) begin
            rd_byte = sense_pos_reg;
        end else if (ar_idx == IDX_W'(IDX_BIAS_CTRL)) begin
            rd_byte = {7'h00, bias_measure_reg};
        end else if (ar_idx == IDX_W'(IDX_STATUS)) begin
            rd_byte = status_byte;
        end
    end

    // read data and response
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            rvalid_reg <= 1'b0;
            rdata_reg <= 32'h0000_0000;
            rresp_reg <= RESP_OKAY;
        end else if (s_axi_arvalid && !rvalid_reg) begin
            rvalid_reg <= 1'b1;
            rdata_reg <= {24'h00_0000, rd_byte};
            rresp_reg <= idx_mapped(ar_idx) ? RESP_OKAY : RESP_SLVERR;
        end else if (s_axi_rready) begin
            rvalid_reg <= 1'b0;
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // decoded controls, registered one cycle behind the fields
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            threshold_high_permille <= 10'd0;
            threshold_low_permille <= 10'd0;
            excitation_current_na <= 15'd0;
            ac_detect_enable <= 1'b0;
            dc_detect_enable <= 1'b0;
            lead_off_positive_sense <= 8'h00;
        end else begin
            threshold_high_permille <= ldr_high_permille(lead_off_reg.comparator_threshold); // [RQ2]
            threshold_low_permille <= ldr_low_permille(lead_off_reg.comparator_threshold); // [RQ3]
            excitation_current_na <= ldr_current_na(lead_off_reg.excitation_current); // [RQ5]
            ac_detect_enable <= lead_off_reg.detection_mode == MODE_AC; // [RQ6]
            dc_detect_enable <= lead_off_reg.detection_mode == MODE_DC; // [RQ6]
            lead_off_positive_sense <= sense_pos_reg; // [RQ18]
        end
    end

    // channel and bias controls
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            channel_settings <= '0;
            amplifier_gain_value <= '0;
            bias_positive_route <= 8'h00;
            bias_measure_enable <= 1'b0;
            bias_measure_route <= 8'h00;
        end else begin
            channel_settings <= chan_reg; // [RQ9] [RQ12] [RQ13]
            bias_positive_route <= bias_pos_reg; // [RQ14]
            bias_measure_enable <= bias_measure_reg;
            for (int i = 0; i < 8; i++) begin
                amplifier_gain_value[i] <= ldr_gain_value(chan_reg[i].amplifier_gain); // [RQ11]
                bias_measure_route[i] <= bias_measure_reg &&
                    chan_reg[i].input_selector == SEL_BIAS_MEASURE; // [RQ17]
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // checks
    default clocking cb @(posedge aclk); endclocking
    default disable iff (!aresetn);

    // a write that lands on the lead-off word
    sequence seq_lead_write;
        wr_en && aw_idx_reg == IDX_W'(IDX_LEAD_OFF);
    endsequence

    chk_reset_values: assert property ($rose(aresetn) |->  // [RQ1] [RQ8]
        lead_off_reg == RST_LEAD_OFF && chan_reg[0] == RST_CHAN && chan_reg[7] == RST_CHAN)
        else $error("register reset value wrong");
    chk_lead_store: assert property (seq_lead_write |=>  // [RQ19]
        lead_off_reg == $past(w_data_reg) && s_axi_bvalid)
        else $error("lead-off write not stored");
    chk_thresh_pair: assert property (1'b1 |=> (threshold_high_permille +  // [RQ2] [RQ3]
        threshold_low_permille == 10'd1000) && ($past(lead_off_reg.comparator_threshold) !=
        3'h0 || threshold_high_permille == 10'd950))
        else $error("comparator thresholds inconsistent");
    chk_current_max: assert property (lead_off_reg.excitation_current == 2'h3 &&  // [RQ5]
        $stable(lead_off_reg) |=> excitation_current_na == 15'd24000)
        else $error("excitation current decode wrong");
    chk_mode_flags: assert property (##1 (ac_detect_enable ==  // [RQ6]
        ($past(lead_off_reg.detection_mode) == MODE_AC)) && !(ac_detect_enable && dc_detect_enable))
        else $error("detection mode decode wrong");
    chk_powerdown_out: assert property (##1 channel_settings[0].channel_powerdown ==  // [RQ9]
        $past(chan_reg[0].channel_powerdown))
        else $error("powerdown not followed");
    chk_gain_top: assert property (chan_reg[2].amplifier_gain == 3'h6 |=>  // [RQ11]
        amplifier_gain_value[2] == 5'd24)
        else $error("gain decode wrong");
    chk_bias_mask: assert property ((bias_pos_reg & ~IMPL_MASK) == 8'h00 &&  // [RQ15]
        (sense_pos_reg & ~IMPL_MASK) == 8'h00)
        else $error("absent channel bit stored");
    chk_bias_measure: assert property (bias_measure_reg &&  // [RQ17]
        chan_reg[1].input_selector == SEL_BIAS_MEASURE |=> bias_measure_route[1])
        else $error("bias measure not routed");
    chk_read_answer: assert property (s_axi_arvalid && s_axi_arready |=>  // [RQ19]
        s_axi_rvalid && s_axi_rdata[31:8] == 24'h00_0000)
        else $error("read answer late or wide");

endmodule

`default_nettype wire

// >>> core/ldr_pkg.sv
// constants, field layouts and decode tables for the channel configuration bank
// assumes a 32-bit axi4-lite master; registers sit in the low byte of each word
//
// Functional notes
// RQ1: lead-off control at index 04h, resets 00h
// RQ2: threshold code picks high-side comparator percentage
// RQ3: same code picks low-side comparator percentage
// RQ4: software writes zero to lead-off bit four
// RQ5: bits 3:2 select excitation current magnitude
// RQ6: bits 1:0 select ac, dc detection mode
// RQ7: software sets mode when any sense bit set
// RQ8: eight channel registers 05h-0Ch, reset 61h
// RQ9: channel bit seven powers the channel down
// RQ10: software should short powered-down channel inputs
// RQ11: channel bits 6:4 select amplifier gain
// RQ12: channel bit three closes shared reference switch
// RQ13: channel bits 2:0 select the channel input
// RQ14: bias positive select at 0Dh, one bit/channel
// RQ15: upper select bits absent in smaller variants
// RQ16: software writes zero to absent select bits
// RQ17: bias measure routes bias input to selector 010
// RQ18: positive lead-off sense at 0Fh, one bit/channel
// RQ19: fields read back last write, reset restores
`default_nettype none

package ldr_pkg;

    ////////////////////////////////////////////////////////////////////////////////
    // register indices; byte address is four times the index
    localparam logic [5:0] IDX_LEAD_OFF = 6'h04;
    localparam logic [5:0] IDX_CHAN_FIRST = 6'h05;
    localparam logic [5:0] IDX_CHAN_LAST = 6'h0c;
    localparam logic [5:0] IDX_BIAS_POS = 6'h0d;
    localparam logic [5:0] IDX_SENSE_POS = 6'h0f;
    localparam logic [5:0] IDX_BIAS_CTRL = 6'h18;
    localparam logic [5:0] IDX_STATUS = 6'h19;

    // reset values
    localparam logic [7:0] RST_LEAD_OFF = 8'h00;
    localparam logic [7:0] RST_CHAN = 8'h61;
    localparam logic [7:0] RST_BIAS_POS = 8'h00;
    localparam logic [7:0] RST_SENSE_POS = 8'h00;
    localparam logic [7:0] RST_BIAS_CTRL = 8'h00;

    // field codes
    localparam logic [1:0] MODE_OFF = 2'h0;
    localparam logic [1:0] MODE_AC = 2'h1;
    localparam logic [1:0] MODE_RSVD = 2'h2;
    localparam logic [1:0] MODE_DC = 2'h3;
    localparam logic [2:0] GAIN_RSVD = 3'h7;
    localparam logic [2:0] SEL_SHORTED = 3'h1;
    localparam logic [2:0] SEL_BIAS_MEASURE = 3'h2;

    // axi responses
    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;

    // lead-off control layout
    typedef struct packed {
        logic [2:0] comparator_threshold;
        logic reserved;
        logic [1:0] excitation_current;
        logic [1:0] detection_mode;
    } ldr_lead_off_t;

    // channel settings layout
    typedef struct packed {
        logic channel_powerdown;
        logic [2:0] amplifier_gain;
        logic shared_ref_switch;
        logic [2:0] input_selector;
    } ldr_chan_t;

    ////////////////////////////////////////////////////////////////////////////////
    // high-side threshold in tenths of a percent
    function automatic logic [9:0] ldr_high_permille(input logic [2:0] code);
        case (code)
            3'h0: return 10'd950;
            3'h1: return 10'd925;
            3'h2: return 10'd900;
            3'h3: return 10'd875;
            3'h4: return 10'd850;
            3'h5: return 10'd800;
            3'h6: return 10'd750;
            default: return 10'd700;
        endcase
    endfunction

    // low-side threshold mirrors the high side about the midpoint
    function automatic logic [9:0] ldr_low_permille(input logic [2:0] code);
        return 10'd1000 - ldr_high_permille(code);
    endfunction

    // excitation current in nanoamps
    function automatic logic [14:0] ldr_current_na(input logic [1:0] code);
        case (code)
            2'h0: return 15'd6;
            2'h1: return 15'd12;
            2'h2: return 15'd6000;
            default: return 15'd24000;
        endcase
    endfunction

    // amplifier gain factor, zero for the unusable code
    function automatic logic [4:0] ldr_gain_value(input logic [2:0] code);
        case (code)
            3'h0: return 5'd1;
            3'h1: return 5'd2;
            3'h2: return 5'd4;
            3'h3: return 5'd6;
            3'h4: return 5'd8;
            3'h5: return 5'd12;
            3'h6: return 5'd24;
            default: return 5'd0;
        endcase
    endfunction

endpackage

`default_nettype wire

// >>> dv/tb_lead_off_channel_config_regs.sv
// self-checking bench for the lead-off and channel configuration bank
// assumes ldr_pkg is compiled first; bench drives the axi4-lite slave directly
`default_nettype none

module tb_lead_off_channel_config_regs;
    timeunit 1ns;
    timeprecision 1ps;
    import ldr_pkg::*;

    ////////////////////////////////////////////////////////////////////////////////
    // expected decode tables, high side, low side, current, gain
    localparam logic [9:0] HI_T [8] = '{10'd950, 10'd925, 10'd900, 10'd875,
                                        10'd850, 10'd800, 10'd750, 10'd700};
    localparam logic [9:0] LO_T [8] = '{10'd50, 10'd75, 10'd100, 10'd125,
                                        10'd150, 10'd200, 10'd250, 10'd300};
    localparam logic [14:0] CUR_T [4] = '{15'd6, 15'd12, 15'd6000, 15'd24000};
    localparam logic [4:0] GAIN_T [8] = '{5'd1, 5'd2, 5'd4, 5'd6, 5'd8, 5'd12, 5'd24, 5'd0};

    // clock, reset and bus signals
    logic aclk = 1'b0;
    logic aresetn = 1'b0;
    logic [7:0] s_axi_awaddr = 8'h00;
    logic s_axi_awvalid = 1'b0;
    logic [31:0] s_axi_wdata = 32'h0;
    logic s_axi_wvalid = 1'b0;
    logic s_axi_bready = 1'b0;
    logic [7:0] s_axi_araddr = 8'h00;
    logic s_axi_arvalid = 1'b0;
    logic s_axi_rready = 1'b0;
    logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
    logic [1:0] s_axi_bresp, s_axi_rresp;
    logic [31:0] s_axi_rdata;
    // decoded outputs
    logic [9:0] thr_high, thr_low;
    logic [14:0] cur_na;
    logic ac_en, dc_en, meas_en;
    logic [7:0] sense_pos, bias_route, meas_route;
    ldr_chan_t [7:0] chan_set;
    logic [7:0][4:0] gain_val;
    // bookkeeping
    int errors = 0;
    int total_checks = 0;
    int cycles = 0;

    ldr_config_regs #(.NUM_CHANNELS(8), .ADDR_W(8)) dut (
        .aclk(aclk), .aresetn(aresetn),
        .s_axi_awaddr(s_axi_awaddr), .s_axi_awprot(3'h0), .s_axi_awvalid(s_axi_awvalid),
        .s_axi_awready(s_axi_awready), .s_axi_wdata(s_axi_wdata), .s_axi_wstrb(4'hf),
        .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp),
        .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready),
        .s_axi_araddr(s_axi_araddr), .s_axi_arprot(3'h0), .s_axi_arvalid(s_axi_arvalid),
        .s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp),
        .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready),
        .threshold_high_permille(thr_high), .threshold_low_permille(thr_low),
        .excitation_current_na(cur_na), .ac_detect_enable(ac_en), .dc_detect_enable(dc_en),
        .lead_off_positive_sense(sense_pos), .channel_settings(chan_set),
        .amplifier_gain_value(gain_val), .bias_positive_route(bias_route),
        .bias_measure_enable(meas_en), .bias_measure_route(meas_route)
    );

    ////////////////////////////////////////////////////////////////////////////////
    // clock generator, 8 ns period
    initial begin
        forever #4 aclk = ~aclk;
    end

    // hang guard, counts a mismatch when the ceiling is reached
    always @(posedge aclk) begin
        cycles <= cycles + 1;
        if (cycles == 20000) begin
            errors++;
            conclude();
        end
    end

    // verdict and end of run
    task automatic conclude();
        if (errors == 0 && total_checks > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask

    // compare a value, zero-extended to a word
    task automatic check_val(input logic [31:0] got, input logic [31:0] exp);
        total_checks++;
        if (got !== exp) begin
            errors++;
            $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    // compare a bus response code
    task automatic check_resp(input logic [1:0] got, input logic [1:0] exp);
        total_checks++;
        if (got !== exp) begin
            errors++;
            $display("ERROR t=%0t resp got=%h exp=%h", $time, got, exp);
        end
    endtask

    ////////////////////////////////////////////////////////////////////////////////
    // bus cycles; handshakes judged at the falling edge, acted on at the next rise
    task automatic axi_write(input logic [5:0] idx, input logic [7:0] data,
                             output logic [1:0] resp);
        logic aw_hit, w_hit, b_hit;
        b_hit = 1'b0;
        @(posedge aclk);
        s_axi_awaddr <= {idx, 2'b00};
        s_axi_wdata <= {24'h0, data};
        s_axi_awvalid <= 1'b1;
        s_axi_wvalid <= 1'b1;
        s_axi_bready <= 1'b1;
        while (!b_hit) begin
            @(negedge aclk);
            aw_hit = s_axi_awvalid && s_axi_awready;
            w_hit = s_axi_wvalid && s_axi_wready;
            b_hit = (s_axi_bvalid === 1'b1);
            resp = s_axi_bresp;
            @(posedge aclk);
            if (aw_hit) s_axi_awvalid <= 1'b0;
            if (w_hit) s_axi_wvalid <= 1'b0;
            if (b_hit) s_axi_bready <= 1'b0;
        end
    endtask

    task automatic axi_read(input logic [5:0] idx, output logic [31:0] data,
                            output logic [1:0] resp);
        logic ar_hit, r_hit;
        r_hit = 1'b0;
        @(posedge aclk);
        s_axi_araddr <= {idx, 2'b00};
        s_axi_arvalid <= 1'b1;
        s_axi_rready <= 1'b1;
        while (!r_hit) begin
            @(negedge aclk);
            ar_hit = s_axi_arvalid && s_axi_arready;
            r_hit = (s_axi_rvalid === 1'b1);
            data = s_axi_rdata;
            resp = s_axi_rresp;
            @(posedge aclk);
            if (ar_hit) s_axi_arvalid <= 1'b0;
            if (r_hit) s_axi_rready <= 1'b0;
        end
    endtask

    // read a register and compare it with an okay answer
    task automatic read_check(input logic [5:0] idx, input logic [7:0] exp);
        logic [31:0] d;
        logic [1:0] r;
        axi_read(idx, d, r);
        check_resp(r, RESP_OKAY);
        check_val(d, {24'h0, exp});
    endtask

    // reset held for four clocks
    task automatic apply_reset();
        aresetn <= 1'b0;
        repeat (4) @(posedge aclk);
        aresetn <= 1'b1;
    endtask

    ////////////////////////////////////////////////////////////////////////////////
    // scenario: lead-off, channel and bias select reads, plus threshold, current, channel and gain outputs, at reset value
    task automatic test_reset_values();
        int i;
        read_check(IDX_LEAD_OFF, RST_LEAD_OFF);
        for (i = 0; i < 8; i++) begin
            read_check(IDX_CHAN_FIRST + 6'(i), 8'h61);
            check_val(32'(chan_set[i]), 32'h61);
            check_val(32'(gain_val[i]), 32'd24);
        end
        read_check(IDX_BIAS_POS, 8'h00);
        check_val(32'(thr_high), 32'd950);
        check_val(32'(thr_low), 32'd50);
        check_val(32'(cur_na), 32'd6);
    endtask

    // scenario: all threshold, current and mode codes through lead-off control
    task automatic test_lead_off();
        int i;
        logic [7:0] v;
        logic [1:0] r;
        for (i = 0; i < 8; i++) begin
            v = {i[2:0], 1'b0, i[1:0], i[1:0]};
            axi_write(IDX_LEAD_OFF, v, r);
            check_resp(r, RESP_OKAY);
            @(negedge aclk);
            check_val(32'(thr_high), 32'(HI_T[i]));
            check_val(32'(thr_low), 32'(LO_T[i]));
            check_val(32'(cur_na), 32'(CUR_T[i[1:0]]));
            check_val(32'(ac_en), 32'(i[1:0] == 2'h1));
            check_val(32'(dc_en), 32'(i[1:0] == 2'h3));
            read_check(IDX_LEAD_OFF, v);
        end
    endtask

    // scenario: distinct settings on each channel, every gain and selector code
    task automatic test_channels();
        int i;
        logic [7:0] v;
        logic [1:0] r;
        for (i = 0; i < 8; i++) begin
            axi_write(IDX_CHAN_FIRST + 6'(i), {(i == 1), i[2:0], i[1], i[2:0]}, r);
            check_resp(r, RESP_OKAY);
        end
        @(negedge aclk);
        for (i = 0; i < 8; i++) begin
            v = {(i == 1), i[2:0], i[1], i[2:0]};
            check_val(32'(chan_set[i].channel_powerdown), 32'(i == 1));
            check_val(32'(chan_set[i].shared_ref_switch), 32'(i[1]));
            check_val(32'(chan_set[i].input_selector), 32'(i[2:0]));
            check_val(32'(gain_val[i]), 32'(GAIN_T[i]));
            read_check(IDX_CHAN_FIRST + 6'(i), v);
        end
    endtask

    // scenario: bias select, sense bits and bias measurement routing
    task automatic test_bias();
        logic [1:0] r;
        axi_write(IDX_BIAS_POS, 8'ha5, r);
        axi_write(IDX_SENSE_POS, 8'h3c, r);
        axi_write(IDX_BIAS_CTRL, 8'h01, r);
        @(negedge aclk);
        check_val(32'(bias_route), 32'ha5);
        read_check(IDX_BIAS_POS, 8'ha5);
        check_val(32'(sense_pos), 32'h3c);
        check_val(32'(meas_en), 32'h1);
        check_val(32'(meas_route), 32'h04);
        axi_write(IDX_BIAS_CTRL, 8'h00, r);
        @(negedge aclk);
        check_val(32'(meas_route), 32'h00);
    endtask

    // scenario: unmapped index and read-only status are refused
    task automatic test_refused();
        logic [31:0] d;
        logic [1:0] r;
        axi_write(6'h0e, 8'hff, r);
        check_resp(r, RESP_SLVERR);
        axi_read(6'h0e, d, r);
        check_resp(r, RESP_SLVERR);
        check_val(d, 32'h0);
        axi_write(IDX_STATUS, 8'hff, r);
        check_resp(r, RESP_SLVERR);
        read_check(IDX_STATUS, 8'h04);
        read_check(IDX_BIAS_POS, 8'ha5);
    endtask

    ////////////////////////////////////////////////////////////////////////////////
    // main sequence, ending with a mid-run reset
    initial begin
        apply_reset();
        repeat (2) @(posedge aclk);
        test_reset_values();
        test_lead_off();
        test_channels();
        test_bias();
        test_refused();
        apply_reset();
        repeat (2) @(posedge aclk);
        test_reset_values();
        conclude();
    end

endmodule

`default_nettype wire
